/* File: chgfault_cfg.svh */
// What this block does
// RL1: Boost inductor current at cycle limit starts overload; output current is limited.
// RL2: Overload lasting over 30ms raises overload fault and restores registers to defaults.
// RL3: Status select 00: status pin low while charging, high impedance otherwise.
// RL4: Status select 01 holds pin low; 10 holds pin high impedance.
// RL5: Charge-mode battery over-voltage stops charging, sets its flag, pulls interrupt low.
// RL6: Hysteresis release resumes charging with default settings and clears the fault.
// RL7: Boost battery over or under voltage stops switching, sets flag, enters high impedance.
// RL8: Under-voltage uses 3V start threshold before boost runs, 2.5V once running.
// RL9: Interrupt output is active low while any attention flag is set.
// RL10: Comparators are synchronised; overload counter restarts whenever overload clears.
// RL11: High impedance disables switching until new mode request or reset; select resets 00.
`ifndef CHGFAULT_CFG_SVH
`define CHGFAULT_CFG_SVH
`define CLK_MHZ 200
`define OVL_TIME_MS 30
`define OVL_CYCLES (`OVL_TIME_MS * 1000 * `CLK_MHZ)
`define STAT_SEL_RESET 2'h0
`endif

/* File: chgfault_pkg.sv */
package chgfault_pkg;
   typedef enum logic [1:0] {
      STAT_CHARGING = 2'b00,
      STAT_LOW = 2'b01,
      STAT_HIZ = 2'b10,
      STAT_RSVD = 2'b11
   } stat_sel_t;
   typedef enum logic [1:0] {
      MODE_IDLE = 2'b00,
      MODE_CHARGE = 2'b01,
      MODE_BOOST = 2'b10,
      MODE_HIZ = 2'b11
   } mode_t;
   typedef struct packed {
      logic bat_ovp;
      logic bat_ovp_rel;
      logic bst_ov;
      logic bst_uv_start;
      logic bst_uv_run;
      logic ilim;
   } cmp_t;
   typedef struct packed {
      logic overload;
      logic chg_bat_ov;
      logic bst_bat_ov;
      logic bst_bat_uv;
   } flags_t;
endpackage

/* File: chgfault_ctrl.sv */
`timescale 1ns/1ps
`include "chgfault_cfg.svh"
module chgfault_ctrl #(
   parameter int unsigned OVL_CYCLES = `OVL_CYCLES
) (
   input wire logic REF_CLK,
   input wire logic NRST,
   input wire chgfault_pkg::cmp_t CMP,
   input wire logic CHARGE_REQ,
   input wire logic BOOST_REQ,
   input wire logic [1:0] STAT_SEL_WR,
   input wire logic STAT_SEL_WE,
   input wire logic FLAG_CLR,
   output logic STAT_OUT,
   output logic STAT_OE,
   output logic INT_N,
   output logic SWITCH_EN,
   output logic CURRENT_LIMIT,
   output logic REG_DEFAULT,
   output chgfault_pkg::mode_t MODE,
   output chgfault_pkg::flags_t FLAGS,
   output logic [1:0] STAT_SEL
);
   // Every property here runs on the one system clock and drops out in reset
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!NRST);

   // ----------------------------------------
   // Comparator synchroniser
   // ----------------------------------------
   localparam int W = $bits(chgfault_pkg::cmp_t);
   logic [W-1:0] s1_r, s2_r, s3_r;
   chgfault_pkg::cmp_t cmp_r;
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
         cmp_r <= '0;
      end else begin
         s1_r <= CMP; // [RL10]
         s2_r <= s1_r;
         s3_r <= s2_r;
         // Accept a change only once two stages agree
         for (int i = 0; i < W; i++) begin
            if (s2_r[i] == s3_r[i]) cmp_r[i] <= s3_r[i];
         end
      end
   end

   // ----------------------------------------
   // Mode and fault decoding
   // ----------------------------------------
   chgfault_pkg::mode_t mode_r, mode_nxt;
   chgfault_pkg::flags_t flags_r, flags_nxt;
   logic [1:0] sel_r, sel_nxt;
   logic [31:0] ovl_cnt_r;
   logic bst_run_r;
   wire in_boost = (mode_r == chgfault_pkg::MODE_BOOST);
   wire in_charge = (mode_r == chgfault_pkg::MODE_CHARGE);
   wire ovl_active = in_boost && cmp_r.ilim; // [RL1]
   wire ovl_fault = ovl_active && (ovl_cnt_r >= OVL_CYCLES); // [RL2]
   // Start threshold guards the first cycle; running threshold is lower
   wire bst_uv = bst_run_r ? cmp_r.bst_uv_run : cmp_r.bst_uv_start; // [RL8]
   wire bst_trip = in_boost && (cmp_r.bst_ov || bst_uv); // [RL7]
   wire chg_ov = in_charge && cmp_r.bat_ovp; // [RL5]
   wire chg_rel = flags_r.chg_bat_ov && cmp_r.bat_ovp_rel; // [RL6]

   always_comb begin
      mode_nxt = mode_r;
      flags_nxt = flags_r;
      sel_nxt = sel_r;
      if (FLAG_CLR) flags_nxt = '0;
      if (STAT_SEL_WE) sel_nxt = STAT_SEL_WR;
      case (mode_r)
         chgfault_pkg::MODE_IDLE, chgfault_pkg::MODE_HIZ: begin
            // High impedance leaves only on a fresh mode request [RL11]
            if (BOOST_REQ) mode_nxt = chgfault_pkg::MODE_BOOST;
            else if (CHARGE_REQ) mode_nxt = chgfault_pkg::MODE_CHARGE;
         end
         chgfault_pkg::MODE_CHARGE: begin
            if (BOOST_REQ) mode_nxt = chgfault_pkg::MODE_BOOST;
         end
         chgfault_pkg::MODE_BOOST: begin
            if (bst_trip) mode_nxt = chgfault_pkg::MODE_HIZ; // [RL7]
            else if (CHARGE_REQ) mode_nxt = chgfault_pkg::MODE_CHARGE;
         end
         default: mode_nxt = chgfault_pkg::MODE_IDLE;
      endcase
      // Hardware sets win over software clear
      if (chg_ov) flags_nxt.chg_bat_ov = 1'b1; // [RL5]
      else if (chg_rel) begin
         flags_nxt.chg_bat_ov = 1'b0; // [RL6]
         sel_nxt = `STAT_SEL_RESET;
      end
      if (bst_trip && cmp_r.bst_ov) flags_nxt.bst_bat_ov = 1'b1; // [RL7]
      if (bst_trip && bst_uv) flags_nxt.bst_bat_uv = 1'b1;
      if (bst_trip) sel_nxt = `STAT_SEL_RESET; // [RL11]
      if (ovl_fault) begin
         flags_nxt.overload = 1'b1; // [RL2]
         sel_nxt = `STAT_SEL_RESET;
      end
   end

   // ----------------------------------------
   // State registers
   // ----------------------------------------
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         mode_r <= chgfault_pkg::MODE_IDLE;
         flags_r <= '0;
         sel_r <= `STAT_SEL_RESET;
         bst_run_r <= 1'b0;
         ovl_cnt_r <= '0;
      end else begin
         mode_r <= mode_nxt;
         flags_r <= flags_nxt;
         sel_r <= sel_nxt;
         bst_run_r <= in_boost && (mode_nxt == chgfault_pkg::MODE_BOOST);
         if (!ovl_active || ovl_fault) ovl_cnt_r <= '0; // [RL10]
         else ovl_cnt_r <= ovl_cnt_r + 32'h1;
      end
   end

   // ----------------------------------------
   // Output flops
   // ----------------------------------------
   wire chg_prog = (mode_nxt == chgfault_pkg::MODE_CHARGE) && !flags_nxt.chg_bat_ov;
   wire stat_low = (sel_nxt == chgfault_pkg::STAT_LOW)
      || ((sel_nxt == chgfault_pkg::STAT_CHARGING) && chg_prog); // [RL3] [RL4]
   // A weak battery must not see even one switching cycle on a boost start
   wire start_block = !in_boost && cmp_r.bst_uv_start; // [RL8]
   wire sw_nxt = ((mode_nxt == chgfault_pkg::MODE_BOOST) && !bst_trip && !start_block)
      || chg_prog;
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         STAT_OUT <= 1'b0;
         STAT_OE <= 1'b0;
         INT_N <= 1'b1;
         SWITCH_EN <= 1'b0;
         CURRENT_LIMIT <= 1'b0;
         REG_DEFAULT <= 1'b0;
         MODE <= chgfault_pkg::MODE_IDLE;
         FLAGS <= '0;
         STAT_SEL <= `STAT_SEL_RESET;
      end else begin
         STAT_OUT <= 1'b0;
         STAT_OE <= stat_low; // [RL3] [RL4]
         INT_N <= ~(|flags_nxt); // [RL9]
         SWITCH_EN <= sw_nxt; // [RL5] [RL11]
         CURRENT_LIMIT <= ovl_active; // [RL1]
         REG_DEFAULT <= ovl_fault || chg_rel; // [RL2]
         MODE <= mode_nxt;
         FLAGS <= flags_nxt;
         STAT_SEL <= sel_nxt;
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   ovl_flag_set_a: assert property (ovl_fault |=> FLAGS.overload && REG_DEFAULT) // [RL2]
      else $error("overload fault not flagged");
   ovl_sel_a: assert property (ovl_fault |=> STAT_SEL == 2'h0) // [RL2]
      else $error("overload did not reset status select");
   ovl_restart_a: assert property (!ovl_active |=> ovl_cnt_r == 0) // [RL10]
      else $error("overload counter not restarted");
   stat_sel_low_a: assert property (STAT_SEL == 2'h1 |-> STAT_OE && !STAT_OUT) // [RL4]
      else $error("status pin not held low");
   stat_sel_hiz_a: assert property (STAT_SEL == 2'h2 |-> !STAT_OE) // [RL4]
      else $error("status pin not released");
   stat_chg_a: assert property ( // [RL3]
      STAT_SEL == 2'h0 |-> STAT_OE == (MODE == chgfault_pkg::MODE_CHARGE && !FLAGS.chg_bat_ov))
      else $error("status pin does not track charging");
   sel_write_a: assert property (STAT_SEL_WE && !bst_trip && !ovl_fault && !chg_rel // [RL4]
      |=> STAT_SEL == $past(STAT_SEL_WR))
      else $error("status select write lost");
   chg_ov_a: assert property (chg_ov |=> FLAGS.chg_bat_ov && !INT_N && !SWITCH_EN) // [RL5]
      else $error("charge over-voltage not handled");
   chg_stop_a: assert property (in_charge && FLAGS.chg_bat_ov |-> !SWITCH_EN) // [RL5]
      else $error("charging during over-voltage");
   chg_rel_a: assert property (chg_rel && !chg_ov |=> !FLAGS.chg_bat_ov && REG_DEFAULT) // [RL6]
      else $error("over-voltage release not handled");
   chg_resume_a: assert property (chg_rel && !chg_ov && in_charge && !BOOST_REQ // [RL6]
      |=> SWITCH_EN)
      else $error("charging not resumed after release");
   bst_trip_a: assert property (bst_trip // [RL7] [RL11]
      |=> MODE == chgfault_pkg::MODE_HIZ && !SWITCH_EN && STAT_SEL == 2'h0)
      else $error("boost trip not entering high impedance");
   // Each boost trip cause leaves its own flag for the host
   bst_ov_flag_a: assert property (bst_trip && cmp_r.bst_ov |=> FLAGS.bst_bat_ov) // [RL7]
      else $error("boost over-voltage flag not set");
   bst_uv_flag_a: assert property (bst_trip && bst_uv |=> FLAGS.bst_bat_uv) // [RL7]
      else $error("boost under-voltage flag not set");
   start_thresh_a: assert property (in_boost && !bst_run_r && cmp_r.bst_uv_start // [RL8]
      |=> MODE == chgfault_pkg::MODE_HIZ)
      else $error("start threshold ignored");
   start_switch_a: assert property (BOOST_REQ && start_block |=> !SWITCH_EN) // [RL8]
      else $error("switching on a weak battery");
   run_thresh_a: assert property (in_boost && bst_run_r && !cmp_r.bst_uv_run // [RL8]
      && !cmp_r.bst_ov |=> MODE != chgfault_pkg::MODE_HIZ)
      else $error("running threshold ignored");
   // Only a fresh request leaves high impedance, never a comparator change
   hiz_hold_a: assert property (MODE == chgfault_pkg::MODE_HIZ && !BOOST_REQ // [RL11]
      && !CHARGE_REQ |=> MODE == chgfault_pkg::MODE_HIZ && !SWITCH_EN)
      else $error("high impedance left without request");
   int_level_a: assert property ((|FLAGS) |-> !INT_N) // [RL9]
      else $error("interrupt not asserted");
   int_release_a: assert property (!(|FLAGS) |-> INT_N) // [RL9]
      else $error("interrupt held without flag");
   // Limiting is a boost-only action
   current_limit_a: assert property (ovl_active |=> CURRENT_LIMIT) // [RL1]
      else $error("current limit not shown");
   limit_boost_a: assert property (!in_boost |=> !CURRENT_LIMIT) // [RL1]
      else $error("current limit outside boost");

   // ----------------------------------------
   // Cover points
   // ----------------------------------------
   cov_ovl_c: cover property (ovl_fault);
   cov_chg_c: cover property (chg_ov ##[1:20] chg_rel);
   cov_bst_c: cover property (bst_trip);
   cov_hiz_exit_c: cover property (MODE == chgfault_pkg::MODE_HIZ ##1 in_charge);
   cov_sel_low_c: cover property (STAT_SEL == 2'h1 && STAT_OE);
endmodule

/* File: host_model.sv */
`timescale 1ns/1ps
module host_model (
   input wire logic REF_CLK,
   input wire logic NRST,
   input wire logic INT_N,
   input wire logic ACK_EN,
   output logic FLAG_CLR
);
   // One-cycle clear per request, so a flag set again shows up as a new interrupt
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) FLAG_CLR <= 1'b0;
      else FLAG_CLR <= ACK_EN && (INT_N === 1'b0) && !FLAG_CLR;
   end
endmodule

/* File: testbench.sv */
`timescale 1ns/1ps
module testbench;
   logic ref_clk, nrst, charge_req, boost_req, sel_we, flag_clr, ack_en;
   logic [1:0] sel_wr, stat_sel;
   chgfault_pkg::cmp_t cmp;
   logic stat_out, stat_oe, int_n, switch_en, current_limit, reg_default;
   chgfault_pkg::mode_t mode;
   chgfault_pkg::flags_t flags;
   int errors = 0;
   int checks = 0;
   int rd_cnt = 0;
   int rd0;
   // Rows: charging, select, expected pin pull-down
   logic [3:0] rows [7] = '{4'h0, 4'h3, 4'h4, 4'h9, 4'hb, 4'hc, 4'he};
   // Boost trip and no-trip cases: comparators before and after the request, resulting mode and flags
   logic [5:0] pre [4] = '{6'h00, 6'h00, 6'h04, 6'h00};
   logic [5:0] post [4] = '{6'h08, 6'h06, 6'h00, 6'h04};
   logic [1:0] em [4] = '{2'h3, 2'h3, 2'h3, 2'h2};
   logic [3:0] ef [4] = '{4'h2, 4'h1, 4'h1, 4'h0};
   chgfault_ctrl #(.OVL_CYCLES(20)) chgfault_ctrl_i (.REF_CLK(ref_clk), .NRST(nrst),
      .CMP(cmp), .CHARGE_REQ(charge_req), .BOOST_REQ(boost_req), .STAT_SEL_WR(sel_wr),
      .STAT_SEL_WE(sel_we), .FLAG_CLR(flag_clr), .STAT_OUT(stat_out), .STAT_OE(stat_oe),
      .INT_N(int_n), .SWITCH_EN(switch_en), .CURRENT_LIMIT(current_limit),
      .REG_DEFAULT(reg_default), .MODE(mode), .FLAGS(flags), .STAT_SEL(stat_sel));
   host_model host_model_i (.REF_CLK(ref_clk), .NRST(nrst), .INT_N(int_n),
      .ACK_EN(ack_en), .FLAG_CLR(flag_clr));
   // ----
   // Helpers
   // ----
   initial begin
      ref_clk = 0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) if (reg_default === 1'b1) rd_cnt++;
   task step(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task restart;
      nrst = 0;
      cmp = '0;
      step(2);
      nrst = 1;
      step(1);
   endtask
   task req(input logic c, input logic b);
      charge_req = c;
      boost_req = b;
      step(1);
      charge_req = 0;
      boost_req = 0;
      step(2);
   endtask
   task wsel(input logic [1:0] v);
      sel_wr = v;
      sel_we = 1;
      step(1);
      sel_we = 0;
      step(2);
   endtask
   task complete_run;
      if (errors == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Run is a few hundred cycles; this is ample margin
   initial begin
      #20000;
      errors++;
      complete_run;
   end
   // ----
   // Tests
   // ----
   initial begin
      nrst = 0;
      charge_req = 0;
      boost_req = 0;
      sel_we = 0;
      sel_wr = 2'h0;
      cmp = '0;
      ack_en = 0;
      step(2);
      nrst = 1;
      step(1);
      check("int_n", int_n, 8'h01);
      check("stat_sel", stat_sel, 8'h00);
      for (int i = 0; i < 7; i++) begin
         if (i == 3) req(1, 0);
         wsel(rows[i][2:1]);
         check("stat_oe", stat_oe, rows[i][0]);
         check("stat_out", stat_out, 8'h00);
      end
      wsel(2'h0);
      cmp.bat_ovp = 1;
      step(8);
      check("chg_ov", flags.chg_bat_ov, 8'h01);
      check("int_n", int_n, 8'h00);
      check("switch", switch_en, 8'h00);
      rd0 = rd_cnt;
      cmp.bat_ovp = 0;
      cmp.bat_ovp_rel = 1;
      step(8);
      cmp.bat_ovp_rel = 0;
      check("chg_ov", flags.chg_bat_ov, 8'h00);
      check("switch", switch_en, 8'h01);
      check("defaults", rd_cnt > rd0, 8'h01);
      // Two runs that only exceed the limit if the count failed to restart
      restart;
      check("mode", mode, chgfault_pkg::MODE_IDLE);
      check("switch", switch_en, 8'h00);
      check("stat_oe", stat_oe, 8'h00);
      wsel(2'h2);
      req(0, 1);
      check("mode", mode, chgfault_pkg::MODE_BOOST);
      cmp.ilim = 1;
      step(18);
      check("limit", current_limit, 8'h01);
      check("switch", switch_en, 8'h01);
      cmp.ilim = 0;
      step(6);
      cmp.ilim = 1;
      step(12);
      check("overload", flags.overload, 8'h00);
      rd0 = rd_cnt;
      step(20);
      check("overload", flags.overload, 8'h01);
      check("stat_sel", stat_sel, 8'h00);
      check("defaults", rd_cnt > rd0, 8'h01);
      cmp.ilim = 0;
      ack_en = 1;
      step(6);
      ack_en = 0;
      check("overload", flags.overload, 8'h00);
      check("int_n", int_n, 8'h01);
      for (int k = 0; k < 4; k++) begin
         restart;
         cmp = pre[k];
         step(6);
         req(0, 1);
         cmp = cmp | post[k];
         step(8);
         check("mode", mode, em[k]);
         check("flags", flags, ef[k]);
         check("switch", switch_en, em[k] == 2'h2);
         cmp = '0;
         req(1, 0);
         check("mode", mode, chgfault_pkg::MODE_CHARGE);
      end
      req(0, 1);
      check("mode", mode, chgfault_pkg::MODE_BOOST);
      check("switch", switch_en, 8'h01);
      complete_run;
   end
endmodule
